// ---- src/dtx_pkg.sv ----
package dtx_pkg;

    // ****************************************************************
    // Widths and register file layout.
    // ****************************************************************
    localparam int DTX_REGS = 32;
    localparam int DTX_AW = 16;
    localparam logic [4:0] DTX_PTR_X_LO = 5'h1a;
    localparam logic [4:0] DTX_PTR_Y_LO = 5'h1c;
    localparam logic [4:0] DTX_PTR_Z_LO = 5'h1e;
    localparam logic [15:0] DTX_PTR_STEP = 16'h0001;
    localparam logic [7:0] DTX_REG_RST = 8'h00;
    localparam logic [7:0] DTX_FLAG_RST = 8'h00;
    localparam logic [15:0] DTX_ADDR_RST = 16'h0000;

    // ****************************************************************
    // Cycle counts of the transfer group.
    // ****************************************************************
    localparam int DTX_CYC_REG = 1;
    localparam int DTX_CYC_MEM = 2;

    // ****************************************************************
    // Operation, pointer and addressing mode encodings.
    // ****************************************************************
    typedef enum logic [2:0] {
        DTX_REG_COPY_OP = 3'h0,
        DTX_REG_PAIR_COPY_OP = 3'h1,
        DTX_LOAD_CONSTANT_OP = 3'h2,
        DTX_POINTER_LOAD_OP = 3'h3,
        DTX_DIRECT_LOAD_OP = 3'h4,
        DTX_POINTER_STORE_OP = 3'h5
    } dtx_op_t;

    typedef enum logic [1:0] {
        DTX_PTR_X = 2'h0,
        DTX_PTR_Y = 2'h1,
        DTX_PTR_Z = 2'h2
    } dtx_ptr_t;

    typedef enum logic [1:0] {
        DTX_AM_PLAIN = 2'h0,
        DTX_AM_POSTINC = 2'h1,
        DTX_AM_PREDEC = 2'h2,
        DTX_AM_DISP = 2'h3
    } dtx_mode_t;

    typedef enum logic [0:0] {
        DTX_ST_IDLE = 1'b0,
        DTX_ST_ACCESS = 1'b1
    } dtx_state_t;

    // ****************************************************************
    // Decoded instruction and data memory request.
    // ****************************************************************
    typedef struct packed {
        logic valid;
        dtx_op_t op;
        dtx_ptr_t ptr;
        dtx_mode_t mode;
        logic [4:0] dst_reg;
        logic [4:0] src_reg;
        logic [7:0] imm;
        logic [5:0] disp;
        logic [15:0] addr;
    } dtx_instr_t;

    typedef struct packed {
        logic rd_en;
        logic wr_en;
        logic [15:0] addr;
        logic [7:0] wdata;
    } dtx_mem_req_t;

endpackage

// ---- src/dtx_exec.sv ----
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RULE1: Register copy writes source register into destination; source unchanged.
// RULE2: Word copy moves register pair (index+1:index) in one operation.
// RULE3: Constant load writes instruction immediate into destination register.
// RULE4: First pointer post-increment load reads at pointer, then adds one.
// RULE5: First pointer pre-decrement load subtracts one, then reads new address.
// RULE6: Second pointer post-increment load reads at pointer, then adds one.
// RULE7: Second pointer pre-decrement load subtracts one, then reads.
// RULE8: Third pointer post-increment load reads at pointer, then adds one.
// RULE9: Third pointer pre-decrement load subtracts one before reading.
// RULE10: Displacement loads read at pointer plus offset; pointer unchanged.
// RULE11: Direct load reads memory at instruction address into destination.
// RULE12: Pointer store writes source at pointer; post-increment adds one after.
// RULE13: Pre-decrement store subtracts one, then writes at updated address.
// RULE14: No transfer instruction alters any flag register bit.
// RULE15: Register ops take one cycle; indirect loads take two cycles.
// RULE16: Pointers are 16-bit register pairs; step wraps over full range.
// RULE17: Pointer update and access finish before next instruction reads pointer.
module dtx_exec
    import dtx_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // Decoded instruction.
    input wire dtx_instr_t instr_i,
    output logic ready_o,
    output logic done_o,
    // Data memory port, read data valid while the read strobe is high.
    output dtx_mem_req_t mem_req_o,
    input wire logic [7:0] mem_rdata_i,
    // Flag register, written only by other instruction groups.
    input wire logic flag_we_i,
    input wire logic [7:0] flag_wdata_i,
    output logic [7:0] flag_register_o,
    // Register file observation port.
    input wire logic [4:0] obs_sel_i,
    output logic [7:0] obs_data_o
);

    // ****************************************************************
    // State.
    // ****************************************************************
    typedef struct packed {
        dtx_state_t state;
        logic ready;
        logic [DTX_REGS-1:0][7:0] rf;
        logic [4:0] load_dst;
        logic load_pend;
        dtx_mem_req_t mem;
        logic done;
        logic [7:0] flags;
        logic [7:0] obs;
    } dtx_core_t;

    dtx_core_t cur_r;
    dtx_core_t cur_nxt;

    // ****************************************************************
    // Helpers.
    // ****************************************************************
    function automatic logic [4:0] ptr_lo(input dtx_ptr_t p);
        case (p)
            DTX_PTR_X: ptr_lo = DTX_PTR_X_LO;
            DTX_PTR_Y: ptr_lo = DTX_PTR_Y_LO;
            default: ptr_lo = DTX_PTR_Z_LO;
        endcase
    endfunction

    function automatic logic [15:0] ptr_get(
        input logic [DTX_REGS-1:0][7:0] rf,
        input dtx_ptr_t p
    );
        logic [4:0] lo;
        lo = ptr_lo(p);
        ptr_get = {rf[lo + 5'h01], rf[lo]}; // [RULE16]
    endfunction

    // ****************************************************************
    // Next state.
    // ****************************************************************
    always_comb begin
        logic [15:0] ptr;
        logic [15:0] ptr_new;
        logic [15:0] ea;
        logic [4:0] lo;
        logic [4:0] dpair;
        logic [4:0] spair;
        ptr = '0;
        ptr_new = '0;
        ea = '0;
        lo = '0;
        dpair = '0;
        spair = '0;
        cur_nxt = cur_r;
        cur_nxt.done = 1'b0;
        cur_nxt.mem.rd_en = 1'b0;
        cur_nxt.mem.wr_en = 1'b0;
        cur_nxt.obs = cur_r.rf[obs_sel_i];
        // Flags follow other groups only; this unit never changes them.
        if (flag_we_i) begin
            cur_nxt.flags = flag_wdata_i; // [RULE14]
        end
        case (cur_r.state)
            DTX_ST_IDLE: begin
                if (instr_i.valid) begin
                    lo = ptr_lo(instr_i.ptr);
                    ptr = ptr_get(cur_r.rf, instr_i.ptr);
                    ptr_new = ptr;
                    ea = ptr;
                    case (instr_i.mode)
                        DTX_AM_POSTINC: begin
                            ptr_new = ptr + DTX_PTR_STEP; // [RULE4] [RULE6] [RULE8] [RULE16]
                        end
                        DTX_AM_PREDEC: begin
                            ptr_new = ptr - DTX_PTR_STEP; // [RULE5] [RULE7] [RULE9] [RULE16]
                            ea = ptr_new; // [RULE13]
                        end
                        DTX_AM_DISP: begin
                            ea = ptr + {10'h000, instr_i.disp}; // [RULE10]
                        end
                        default: begin
                            ea = ptr;
                        end
                    endcase
                    dpair = {instr_i.dst_reg[4:1], 1'b0};
                    spair = {instr_i.src_reg[4:1], 1'b0};
                    case (instr_i.op)
                        DTX_REG_COPY_OP: begin
                            cur_nxt.rf[instr_i.dst_reg] =
                                cur_r.rf[instr_i.src_reg]; // [RULE1] [RULE15]
                            cur_nxt.done = 1'b1;
                        end
                        DTX_REG_PAIR_COPY_OP: begin
                            cur_nxt.rf[dpair] = cur_r.rf[spair]; // [RULE2]
                            cur_nxt.rf[dpair + 5'h01] =
                                cur_r.rf[spair + 5'h01]; // [RULE2] [RULE15]
                            cur_nxt.done = 1'b1;
                        end
                        DTX_LOAD_CONSTANT_OP: begin
                            cur_nxt.rf[instr_i.dst_reg] = instr_i.imm; // [RULE3]
                            cur_nxt.done = 1'b1; // [RULE15]
                        end
                        DTX_POINTER_LOAD_OP, DTX_POINTER_STORE_OP: begin
                            // Pointer written back in the issue cycle.
                            cur_nxt.rf[lo] = ptr_new[7:0]; // [RULE17]
                            cur_nxt.rf[lo + 5'h01] = ptr_new[15:8];
                            cur_nxt.mem.addr = ea;
                            cur_nxt.state = DTX_ST_ACCESS; // [RULE15]
                            if (instr_i.op == DTX_POINTER_STORE_OP) begin
                                cur_nxt.mem.wr_en = 1'b1; // [RULE12] [RULE13]
                                cur_nxt.mem.wdata =
                                    cur_r.rf[instr_i.src_reg];
                                cur_nxt.load_pend = 1'b0;
                            end else begin
                                cur_nxt.mem.rd_en = 1'b1;
                                cur_nxt.load_dst = instr_i.dst_reg;
                                cur_nxt.load_pend = 1'b1;
                            end
                        end
                        DTX_DIRECT_LOAD_OP: begin
                            cur_nxt.mem.addr = instr_i.addr; // [RULE11]
                            cur_nxt.mem.rd_en = 1'b1;
                            cur_nxt.load_dst = instr_i.dst_reg;
                            cur_nxt.load_pend = 1'b1;
                            cur_nxt.state = DTX_ST_ACCESS;
                        end
                        default: begin
                            cur_nxt.done = 1'b1;
                        end
                    endcase
                end
            end
            DTX_ST_ACCESS: begin
                // Second cycle: memory answers, result lands in Rd.
                if (cur_r.load_pend) begin
                    cur_nxt.rf[cur_r.load_dst] = mem_rdata_i; // [RULE15]
                end
                cur_nxt.load_pend = 1'b0;
                cur_nxt.done = 1'b1;
                cur_nxt.state = DTX_ST_IDLE; // [RULE17]
            end
            default: begin
                cur_nxt.state = DTX_ST_IDLE;
            end
        endcase
        // Ready is kept in its own flop so the output has no decode logic.
        cur_nxt.ready = (cur_nxt.state == DTX_ST_IDLE); // [RULE17]
    end

    // ****************************************************************
    // State register.
    // ****************************************************************
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cur_r.state <= DTX_ST_IDLE;
            cur_r.ready <= 1'b1;
            cur_r.rf <= {DTX_REGS{DTX_REG_RST}};
            cur_r.load_dst <= 5'h00;
            cur_r.load_pend <= 1'b0;
            cur_r.mem.rd_en <= 1'b0;
            cur_r.mem.wr_en <= 1'b0;
            cur_r.mem.addr <= DTX_ADDR_RST;
            cur_r.mem.wdata <= DTX_REG_RST;
            cur_r.done <= 1'b0;
            cur_r.flags <= DTX_FLAG_RST;
            cur_r.obs <= DTX_REG_RST;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************
    assign ready_o = cur_r.ready;
    assign done_o = cur_r.done;
    assign mem_req_o = cur_r.mem;
    assign flag_register_o = cur_r.flags;
    assign obs_data_o = cur_r.obs;

endmodule // dtx_exec

`default_nettype wire

// ---- verification/dtx_exec_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module dtx_exec_assertions
    import dtx_pkg::*;
(
    // Clock and reset.
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // Instruction port.
    input wire dtx_instr_t instr_i,
    input wire logic ready_o,
    input wire logic done_o,
    // Memory, flag and observation ports.
    input wire dtx_mem_req_t mem_req_o,
    input wire logic [7:0] mem_rdata_i,
    input wire logic flag_we_i,
    input wire logic [7:0] flag_wdata_i,
    input wire logic [7:0] flag_register_o,
    input wire logic [4:0] obs_sel_i,
    input wire logic [7:0] obs_data_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_take;
        ready_o && instr_i.valid;
    endsequence
    sequence s_reg_take;
        s_take ##0 instr_i.op inside {DTX_REG_COPY_OP,
            DTX_REG_PAIR_COPY_OP, DTX_LOAD_CONSTANT_OP};
    endsequence
    sequence s_rd_take;
        s_take ##0 instr_i.op inside {DTX_POINTER_LOAD_OP, DTX_DIRECT_LOAD_OP};
    endsequence
    sequence s_mem_done;
        !ready_o ##1 (ready_o && done_o);
    endsequence
    a_reg_one_cycle: assert property (s_reg_take |=> done_o && ready_o)
        else $error("Register op not done in one cycle.");
    a_reg_no_access: assert property (s_reg_take |=> !mem_req_o.rd_en &&
        !mem_req_o.wr_en) else $error("Register op touched memory.");
    a_rd_two_cycle: assert property (s_rd_take |=> s_mem_done)
        else $error("Load not done in two cycles.");
    a_rd_strobe: assert property (s_rd_take |=> mem_req_o.rd_en &&
        !mem_req_o.wr_en) else $error("Load without read strobe.");
    a_st_strobe: assert property (s_take ##0 instr_i.op ==
        DTX_POINTER_STORE_OP |=> mem_req_o.wr_en && !mem_req_o.rd_en)
        else $error("Store without write strobe.");
    a_direct_addr: assert property (s_take ##0 instr_i.op ==
        DTX_DIRECT_LOAD_OP |=> mem_req_o.addr == $past(instr_i.addr))
        else $error("Direct load address wrong.");
    a_access_busy: assert property (mem_req_o.rd_en || mem_req_o.wr_en
        |-> !ready_o) else $error("Ready during access.");
    a_flag_hold: assert property (!flag_we_i |=> $stable(flag_register_o))
        else $error("Flags changed without write.");
    a_flag_load: assert property (flag_we_i |=>
        flag_register_o == $past(flag_wdata_i)) else $error("Flag write lost.");
endmodule // dtx_exec_assertions
`default_nettype wire

// ---- verification/dtx_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dtx_mem_model
    import dtx_pkg::*;
(
    // Clock.
    input wire logic clk_i,
    // Request and read data.
    input wire dtx_mem_req_t req_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:65535];
    logic [7:0] last = 8'h00;
    initial for (int a = 0; a < 65536; a++) mem[a] = 8'(a ^ (a >> 8)) ^ 8'h3c;
    always @(posedge clk_i) begin
        if (req_i.wr_en) mem[req_i.addr] <= req_i.wdata;
        if (req_i.rd_en) last <= rdata_o;
    end
    // Outside a read the data lines show the inverse of the last byte.
    assign rdata_o = req_i.rd_en ? mem[req_i.addr] : ~last;
endmodule // dtx_mem_model
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import dtx_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic flag_we = 1'b0;
    logic [7:0] flag_wd = 8'h5a;
    logic [4:0] sel = 5'h00;
    dtx_instr_t instr = '0;
    logic ready, done;
    logic [7:0] flags, obs, rdata;
    dtx_mem_req_t req;
    int error_cnt = 0;
    int checked = 0;
    dtx_exec uut (.clk_sys_i, .arst_n_i, .instr_i(instr), .ready_o(ready),
        .done_o(done), .mem_req_o(req), .mem_rdata_i(rdata),
        .flag_we_i(flag_we), .flag_wdata_i(flag_wd),
        .flag_register_o(flags), .obs_sel_i(sel), .obs_data_o(obs));
    dtx_mem_model mem (.clk_i(clk_sys_i), .req_i(req), .rdata_o(rdata));
    initial forever #20 clk_sys_i = ~clk_sys_i;
    // ****************************************************************
    // Shared tasks.
    // ****************************************************************
    task automatic report_and_stop;
        if (error_cnt == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    function automatic logic [7:0] mf(logic [15:0] a);
        mf = a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction
    function automatic dtx_instr_t mk(dtx_op_t o, dtx_ptr_t p = DTX_PTR_X,
        dtx_mode_t m = DTX_AM_PLAIN, logic [4:0] d = 5'h00, s = 5'h00,
        logic [7:0] k = 8'h00, logic [15:0] a = 16'h0000);
        mk = '{1'b1, o, p, m, d, s, k, 6'h3f, a};
    endfunction
    task automatic run(input dtx_instr_t i, output int n,
        output dtx_mem_req_t r);
        instr = i;
        @(posedge clk_sys_i);
        #1 instr.valid = 1'b0;
        r = req;
        n = 0;
        while (done !== 1'b1 && n < 4) begin
            @(posedge clk_sys_i);
            #1 n++;
        end
        // One idle edge, so two requests never meet in one time step.
        @(posedge clk_sys_i);
        #1;
    endtask
    task automatic load_constant_op(input logic [4:0] d, input logic [7:0] k);
        int n;
        dtx_mem_req_t r;
        run(mk(DTX_LOAD_CONSTANT_OP, .d(d), .k(k)), n, r);
        chk("ldi_cyc", 16'h0000, 16'(n));
    endtask
    task automatic getp(input logic [4:0] lo, output logic [15:0] g);
        sel = lo;
        @(posedge clk_sys_i);
        #1 g[7:0] = obs;
        sel = lo + 5'h01;
        @(posedge clk_sys_i);
        #1 g[15:8] = obs;
    endtask
    task automatic setp(input logic [4:0] lo, input logic [15:0] v);
        load_constant_op(lo, v[7:0]);
        load_constant_op(lo + 5'h01, v[15:8]);
    endtask
    // ****************************************************************
    // Scenarios.
    // ****************************************************************
    task automatic t_reg;
        logic [15:0] g;
        int n;
        dtx_mem_req_t r;
        load_constant_op(5'h01, 8'ha5);
        setp(5'h06, 16'h3412);
        run(mk(DTX_REG_COPY_OP, .d(5'h02), .s(5'h01)), n, r);
        chk("mov_cyc", 16'h0000, 16'(n));
        run(mk(DTX_REG_PAIR_COPY_OP, .d(5'h04), .s(5'h06)), n, r);
        chk("reg_pair_copy_op_cyc", 16'h0000, 16'(n));
        getp(5'h01, g);
        chk("mov", 16'ha5a5, g);
        getp(5'h04, g);
        chk("reg_pair_copy_op", 16'h3412, g);
    endtask
    task automatic t_ptr;
        logic [15:0] b, a, np, g;
        logic [4:0] lo;
        int n, p, m;
        dtx_mem_req_t r;
        for (int i = 0; i < 12; i++) begin
            p = i / 4;
            m = i % 4;
            lo = DTX_PTR_X_LO + 5'(2 * p);
            b = (m == 1) ? 16'hffff : (m == 2) ? 16'h0000 : 16'h1234;
            a = (m == 2) ? b - 16'h0001 : (m == 3) ? b + 16'h003f : b;
            np = (m == 1) ? b + 16'h0001 : (m == 2) ? a : b;
            if (i == 3) continue;
            setp(lo, b);
            run(mk(DTX_POINTER_LOAD_OP, dtx_ptr_t'(p), dtx_mode_t'(m),
                5'h03), n, r);
            chk("ld_cyc", 16'h0001, 16'(n));
            chk("ld_addr", a, r.addr);
            getp(5'h03, g);
            chk("ld_data", {8'h00, mf(a)}, {8'h00, g[7:0]});
            getp(lo, g);
            chk("ld_ptr", np, g);
        end
    endtask
    task automatic t_store;
        logic [15:0] a, g;
        logic [4:0] lo;
        int n;
        dtx_mem_req_t r;
        for (int m = 0; m < 3; m++) begin
            lo = DTX_PTR_X_LO + 5'(2 * m);
            a = (m == 2) ? 16'h1fff : 16'h2000;
            setp(lo, 16'h2000);
            run(mk(DTX_POINTER_STORE_OP, dtx_ptr_t'(m), dtx_mode_t'(m),
                .s(5'h01)), n, r);
            chk("st_addr", a, r.addr);
            chk("st_wr", 16'h01a5, {7'h00, r.wr_en, r.wdata});
            getp(lo, g);
            chk("st_ptr", (m == 1) ? 16'h2001 : a, g);
            run(mk(DTX_DIRECT_LOAD_OP, .d(5'h08), .a(a)), n, r);
            chk("lds_cyc", 16'h0001, 16'(n));
            getp(5'h08, g);
            chk("lds", 16'h00a5, {8'h00, g[7:0]});
        end
    endtask
    initial begin
        repeat (16) @(posedge clk_sys_i);
        #1 arst_n_i = 1'b1;
        flag_we = 1'b1;
        @(posedge clk_sys_i);
        #1 flag_we = 1'b0;
        t_reg();
        chk("flags_a", 16'h005a, {8'h00, flags});
        flag_wd = 8'hc3;
        flag_we = 1'b1;
        @(posedge clk_sys_i);
        #1 flag_we = 1'b0;
        t_ptr();
        t_store();
        chk("flags", 16'h00c3, {8'h00, flags});
        report_and_stop();
    end
    initial begin
        #200000;
        error_cnt++;
        report_and_stop();
    end
endmodule // tb_top
bind dtx_exec dtx_exec_assertions u_chk (.clk_sys_i, .arst_n_i, .instr_i,
    .ready_o, .done_o, .mem_req_o, .mem_rdata_i, .flag_we_i, .flag_wdata_i,
    .flag_register_o, .obs_sel_i, .obs_data_o);
`default_nettype wire
